/* acr_map.svh */
// Purpose: Address, field and constant map of the converter config bank
// Assumes: 16-bit serial frames, 5 address bits then 11 data bits
// Notes:   Definitions only
`ifndef ACR_MAP_SVH
`define ACR_MAP_SVH

// ----------------------------------------------------------------
// Serial frame
// ----------------------------------------------------------------
`define ACR_ADDR_W      5
`define ACR_DATA_W      11
`define ACR_FRAME_W     16
`define ACR_CNT_LAST    5'h0F
`define ACR_CNT_ZERO    5'h00

// ----------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------
`define ACR_REG_PWR     5'h00
`define ACR_REG_TIM     5'h04
`define ACR_REG_DDR     5'h09
`define ACR_REG_FMT     5'h0A
`define ACR_REG_ULO     5'h0B
`define ACR_REG_TRIM    5'h0C

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define ACR_B_SLEEP     0
`define ACR_B_CLKOFF    2
`define ACR_B_CLEAR     4
`define ACR_B_BIAS      5
`define ACR_B_STD       8
`define ACR_B_BOOST     9
`define ACR_B_BUFOFF    10
`define ACR_B_CLKDLY    8
`define ACR_B_EDGE      9
`define ACR_B_LAUNCH    10
`define ACR_B_ORDER     10
`define ACR_B_FMT       10
`define ACR_F_PAT       7:5
`define ACR_F_ULO       10:4
`define ACR_F_UHI       4:0
`define ACR_F_TRIM      10:8

// ----------------------------------------------------------------
// Values
// ----------------------------------------------------------------
`define ACR_WORD_ZERO   14'h0000
`define ACR_WORD_ONES   14'h3FFF
`define ACR_WORD_ONE    14'h0001
`define ACR_TOG_A       14'h2AAA
`define ACR_TOG_B       14'h1555
`define ACR_LANE_ZERO   7'h00
`define ACR_UPAD        2'h0

`endif

/* acr_pkg.sv */
// Purpose: Types shared by the converter config bank
// Assumes: Encodings follow the pattern select field
// Notes:   Used only through acr_pkg::name
package acr_pkg;

  typedef enum logic [2:0] {
    ACR_PAT_ADC   = 3'h0,
    ACR_PAT_ZERO  = 3'h1,
    ACR_PAT_ONES  = 3'h2,
    ACR_PAT_TOG   = 3'h3,
    ACR_PAT_RAMP  = 3'h4,
    ACR_PAT_USER  = 3'h5
  } acr_pattern_t;

  typedef enum logic [1:0] {
    ACR_RX_IDLE,
    ACR_RX_SHIFT,
    ACR_RX_HOLD
  } acr_rx_state_t;

endpackage : acr_pkg

/* acr_serial_rx.sv */
// Purpose: 3-wire serial write port, sampled by the system clock
// Assumes: Serial clock far slower than sys_clk; data taken at its fall
// Notes:   Write only; a frame cut short by the enable is dropped
`include "acr_map.svh"

module acr_serial_rx (
  input  wire logic                   sys_clk,
  input  wire logic                   reset_n,
  input  wire logic                   clk_en,
  input  wire logic                   ser_clk,
  input  wire logic                   ser_enable_n,
  input  wire logic                   ser_data,
  output logic                        wr_stb,
  output logic [`ACR_ADDR_W-1:0]      wr_addr,
  output logic [`ACR_DATA_W-1:0]      wr_data
);

  logic [2:0]                sclk_ff;
  logic [1:0]                sen_ff;
  logic [1:0]                sdat_ff;
  logic [`ACR_FRAME_W-1:0]   shift_ff;
  logic [4:0]                cnt_ff;
  logic                      stb_ff;
  acr_pkg::acr_rx_state_t    state_ff;
  acr_pkg::acr_rx_state_t    nxt_state;

  // ----------------------------------------------------------------
  // Synchronisers; stage 0 feeds only stage 1
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      sclk_ff <= 3'h0;
      sen_ff  <= 2'h3;
      sdat_ff <= 2'h0;
    end else if (clk_en) begin
      sclk_ff <= {sclk_ff[1:0], ser_clk};
      sen_ff  <= {sen_ff[0], ser_enable_n};
      sdat_ff <= {sdat_ff[0], ser_data};
    end
  end

  wire sclk_fall = sclk_ff[2] & ~sclk_ff[1];
  wire frame_on  = ~sen_ff[1];
  wire take_bit  = (state_ff == acr_pkg::ACR_RX_SHIFT) & frame_on & sclk_fall;
  wire last_bit  = take_bit & (cnt_ff == `ACR_CNT_LAST);

  // ----------------------------------------------------------------
  // Frame sequencer
  // ----------------------------------------------------------------
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      acr_pkg::ACR_RX_IDLE:  if (frame_on) nxt_state = acr_pkg::ACR_RX_SHIFT;
      acr_pkg::ACR_RX_SHIFT: begin
        if (!frame_on) nxt_state = acr_pkg::ACR_RX_IDLE;
        else if (last_bit) nxt_state = acr_pkg::ACR_RX_HOLD;
      end
      // Extra clocks after the 16th bit are ignored until the frame ends
      acr_pkg::ACR_RX_HOLD:  if (!frame_on) nxt_state = acr_pkg::ACR_RX_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_ff <= acr_pkg::ACR_RX_IDLE;
      cnt_ff   <= `ACR_CNT_ZERO;
      shift_ff <= '0;
      stb_ff   <= 1'b0;
    end else if (clk_en) begin
      state_ff <= nxt_state;
      stb_ff   <= last_bit;
      if (state_ff == acr_pkg::ACR_RX_IDLE) cnt_ff <= `ACR_CNT_ZERO;
      else if (take_bit) cnt_ff <= 5'(cnt_ff + 5'h01);
      if (take_bit) shift_ff <= {shift_ff[`ACR_FRAME_W-2:0], sdat_ff[1]};
    end
  end

  assign wr_stb  = stb_ff;
  assign wr_addr = shift_ff[`ACR_FRAME_W-1:`ACR_DATA_W];
  assign wr_data = shift_ff[`ACR_DATA_W-1:0];

endmodule : acr_serial_rx

/* acr_top.sv */
// Purpose: Converter configuration bank with test patterns and DDR lanes
// Assumes: One sample per two sys_clk cycles; adc_sample is offset binary
// Notes:   Fields feed the analog and output stages as plain levels
//
// What this block does
// - One write updates every field of the addressed register together.
// - Sleep bit powers down only the converter core.
// - Clock buffer off bit tri-states only the output clock.
// - Soft clear bit resets all config registers, then reads as zero.
// - Bias source bit picks internal source at 0, external at 1.
// - Standard bit picks parallel CMOS at 0, DDR LVDS at 1.
// - Coarse boost bit gives 0 dB or 3.5 dB gain.
// - Buffers off bit disables data and clock output buffers.
// - Clock delay bit shifts the output clock by 400 ps.
// - Edge bit sets capture on rising (0) or falling (1) clock edge.
// - Launch shift bit delays data transitions by half a cycle.
// - Bit-wise order sends even bits on rise, odd bits on fall.
// - Byte-wise order sends low half on rise, high half on fall.
// - Pattern select gives converter data, all zeros or all ones.
// - Toggle pattern alternates 0x2AAA and 0x1555 each sample.
// - Ramp pattern counts up one code per sample.
// - User pattern drives the high and low user words joined.
// - Low user word holds the lower seven pattern bits.
// - High user word holds the upper five pattern bits.
// - Format bit picks two's complement at 0, offset binary at 1.
// - Fine trim field sets 0 to 6 dB gain in 1 dB steps.
`include "acr_map.svh"

module acr_top #(
  parameter bit BYTE_ORDER_POL = 1'b0
) (
  input  wire logic         sys_clk,
  input  wire logic         reset_n,
  input  wire logic         clk_en,
  input  wire logic         ser_clk,
  input  wire logic         ser_enable_n,
  input  wire logic         ser_data,
  input  wire logic [13:0]  adc_sample,
  output logic              converter_sleep,
  output logic              outclk_buffer_off,
  output logic              soft_clear,
  output logic              bias_source_sel,
  output logic              output_standard_sel,
  output logic              coarse_boost_sel,
  output logic              output_buffers_off,
  output logic              outclk_delay_sel,
  output logic              capture_edge_sel,
  output logic              sample_launch_shift,
  output logic              ddr_order_sel,
  output logic [2:0]        pattern_sel,
  output logic              code_format_sel,
  output logic [6:0]        user_word_lo,
  output logic [4:0]        user_word_hi,
  output logic [2:0]        trim_amplification,
  output logic [13:0]       output_word,
  output logic [6:0]        ddr_lane,
  output logic              output_clock_pos,
  output logic              output_clock_oe,
  output logic              data_oe
);

  // ----------------------------------------------------------------
  // Serial write port
  // ----------------------------------------------------------------
  logic                      wr_stb;
  logic [`ACR_ADDR_W-1:0]    wr_addr;
  logic [`ACR_DATA_W-1:0]    wr_data;

  acr_serial_rx u_rx (
    .sys_clk      (sys_clk),
    .reset_n      (reset_n),
    .clk_en       (clk_en),
    .ser_clk      (ser_clk),
    .ser_enable_n (ser_enable_n),
    .ser_data     (ser_data),
    .wr_stb       (wr_stb),
    .wr_addr      (wr_addr),
    .wr_data      (wr_data)
  );

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [6:0] even_bits(input logic [13:0] w);
    logic [6:0] r;
    r = `ACR_LANE_ZERO;
    for (int i = 0; i < 7; i++) r[i] = w[2*i];
    return r;
  endfunction : even_bits

  function automatic logic [6:0] odd_bits(input logic [13:0] w);
    logic [6:0] r;
    r = `ACR_LANE_ZERO;
    for (int i = 0; i < 7; i++) r[i] = w[2*i+1];
    return r;
  endfunction : odd_bits

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  // Undefined bit positions are never stored, so stray ones do no harm
  wire wr_pwr  = wr_stb & (wr_addr == `ACR_REG_PWR);
  wire wr_tim  = wr_stb & (wr_addr == `ACR_REG_TIM);
  wire wr_ddr  = wr_stb & (wr_addr == `ACR_REG_DDR);
  wire wr_fmt  = wr_stb & (wr_addr == `ACR_REG_FMT);
  wire wr_ulo  = wr_stb & (wr_addr == `ACR_REG_ULO);
  wire wr_trim = wr_stb & (wr_addr == `ACR_REG_TRIM);
  wire do_clear = wr_pwr & wr_data[`ACR_B_CLEAR];

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  logic        sleep_ff, clkoff_ff, clear_ff, bias_ff, std_ff, boost_ff;
  logic        bufoff_ff, clkdly_ff, edge_ff, launch_ff, order_ff, fmt_ff;
  logic [2:0]  pat_ff, trim_ff;
  logic [6:0]  ulo_ff;
  logic [4:0]  uhi_ff;

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      {sleep_ff, clkoff_ff, bias_ff, std_ff, boost_ff, bufoff_ff} <= '0;
      {clkdly_ff, edge_ff, launch_ff, order_ff, fmt_ff} <= '0;
      {pat_ff, trim_ff, ulo_ff, uhi_ff} <= '0;
      clear_ff <= 1'b0;
    end else if (clk_en) begin
      // Pulses for one cycle only, so the bit always reads back clear
      clear_ff <= do_clear;
      if (do_clear) begin
        {sleep_ff, clkoff_ff, bias_ff, std_ff, boost_ff, bufoff_ff} <= '0;
        {clkdly_ff, edge_ff, launch_ff, order_ff, fmt_ff} <= '0;
        {pat_ff, trim_ff, ulo_ff, uhi_ff} <= '0;
      end else begin
        if (wr_pwr) begin
          sleep_ff  <= wr_data[`ACR_B_SLEEP];
          clkoff_ff <= wr_data[`ACR_B_CLKOFF];
          bias_ff   <= wr_data[`ACR_B_BIAS];
          std_ff    <= wr_data[`ACR_B_STD];
          boost_ff  <= wr_data[`ACR_B_BOOST];
          bufoff_ff <= wr_data[`ACR_B_BUFOFF];
        end
        if (wr_tim) begin
          clkdly_ff <= wr_data[`ACR_B_CLKDLY];
          edge_ff   <= wr_data[`ACR_B_EDGE];
          launch_ff <= wr_data[`ACR_B_LAUNCH];
        end
        if (wr_ddr) order_ff <= wr_data[`ACR_B_ORDER];
        if (wr_fmt) begin
          fmt_ff <= wr_data[`ACR_B_FMT];
          pat_ff <= wr_data[`ACR_F_PAT];
        end
        if (wr_ulo) ulo_ff <= wr_data[`ACR_F_ULO];
        if (wr_trim) begin
          uhi_ff  <= wr_data[`ACR_F_UHI];
          // The eighth code is passed on as written; software avoids it
          trim_ff <= wr_data[`ACR_F_TRIM];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Test pattern generator
  // ----------------------------------------------------------------
  logic        phase_ff, ramp_on_ff, oclk_ff, ocoe_ff, doe_ff;
  logic [13:0] word_ff;
  logic [6:0]  lane_ff;
  logic [13:0] nxt_word;

  // Launch shift moves the load to the other half of the sample period
  wire        word_load  = (phase_ff == launch_ff);
  wire        bitwise    = ~(order_ff ^ BYTE_ORDER_POL);
  wire [13:0] adc_coded  = fmt_ff ? adc_sample
                                  : {~adc_sample[13], adc_sample[12:0]};
  wire [13:0] user_word  = {`ACR_UPAD, uhi_ff, ulo_ff};
  wire [13:0] tog_next   = (word_ff == `ACR_TOG_A) ? `ACR_TOG_B
                                                   : `ACR_TOG_A;
  // 14-bit add wraps from the top code back to zero
  wire [13:0] ramp_next  = ramp_on_ff ? 14'(word_ff + `ACR_WORD_ONE)
                                      : `ACR_WORD_ZERO;
  wire [6:0]  rise_half  = bitwise ? even_bits(word_ff) : word_ff[6:0];
  wire [6:0]  fall_half  = bitwise ? odd_bits(word_ff) : word_ff[13:7];
  // Rise half leaves on the edge after a load, fall half on the next load
  // edge, so both halves come from one word; launch shift slides the pair
  wire [6:0]  nxt_lane   = !std_ff ? `ACR_LANE_ZERO
                         : word_load ? fall_half : rise_half;
  wire        nxt_oclk   = phase_ff ^ edge_ff;

  always_comb begin
    nxt_word = `ACR_WORD_ZERO;
    unique case (pat_ff)
      acr_pkg::ACR_PAT_ADC:  nxt_word = adc_coded;
      acr_pkg::ACR_PAT_ZERO: nxt_word = `ACR_WORD_ZERO;
      acr_pkg::ACR_PAT_ONES: nxt_word = `ACR_WORD_ONES;
      acr_pkg::ACR_PAT_TOG:  nxt_word = tog_next;
      acr_pkg::ACR_PAT_RAMP: nxt_word = ramp_next;
      acr_pkg::ACR_PAT_USER: nxt_word = user_word;
      // Unused codes give a quiet all-zero word
      default:               nxt_word = `ACR_WORD_ZERO;
    endcase
  end

  // ----------------------------------------------------------------
  // Output stage
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      phase_ff   <= 1'b0;
      ramp_on_ff <= 1'b0;
      word_ff    <= `ACR_WORD_ZERO;
      lane_ff    <= `ACR_LANE_ZERO;
      oclk_ff    <= 1'b0;
      ocoe_ff    <= 1'b0;
      doe_ff     <= 1'b0;
    end else if (clk_en) begin
      phase_ff <= ~phase_ff;
      if (word_load) begin
        word_ff    <= nxt_word;
        ramp_on_ff <= (pat_ff == acr_pkg::ACR_PAT_RAMP) & ~do_clear;
      end
      lane_ff <= nxt_lane;
      oclk_ff <= nxt_oclk;
      ocoe_ff <= ~(clkoff_ff | bufoff_ff);
      doe_ff  <= ~bufoff_ff;
    end
  end

  assign converter_sleep     = sleep_ff;
  assign outclk_buffer_off   = clkoff_ff;
  assign soft_clear          = clear_ff;
  assign bias_source_sel     = bias_ff;
  assign output_standard_sel = std_ff;
  assign coarse_boost_sel    = boost_ff;
  assign output_buffers_off  = bufoff_ff;
  assign outclk_delay_sel    = clkdly_ff;
  assign capture_edge_sel    = edge_ff;
  assign sample_launch_shift = launch_ff;
  assign ddr_order_sel       = order_ff;
  assign pattern_sel         = pat_ff;
  assign code_format_sel     = fmt_ff;
  assign user_word_lo        = ulo_ff;
  assign user_word_hi        = uhi_ff;
  assign trim_amplification  = trim_ff;
  assign output_word         = word_ff;
  assign ddr_lane            = lane_ff;
  assign output_clock_pos    = oclk_ff;
  assign output_clock_oe     = ocoe_ff;
  assign data_oe             = doe_ff;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  sequence s_clear_wr;
    clk_en && do_clear;
  endsequence
  sequence s_fields_zero;
    soft_clear && pattern_sel == 3'h0 && !output_standard_sel
      && user_word_lo == 7'h00 && trim_amplification == 3'h0;
  endsequence
  property p_soft_clear;
    s_clear_wr |=> s_fields_zero ##1 (!soft_clear || $past(do_clear));
  endproperty
  a_soft_clear: assert property (p_soft_clear)
    else $error("soft clear did not zero fields or self clear");

  property p_multi_field;
    clk_en && wr_pwr && !do_clear
      |=> converter_sleep == $past(wr_data[`ACR_B_SLEEP])
      && output_standard_sel == $past(wr_data[`ACR_B_STD])
      && coarse_boost_sel == $past(wr_data[`ACR_B_BOOST])
      && output_buffers_off == $past(wr_data[`ACR_B_BUFOFF]);
  endproperty
  a_multi_field: assert property (p_multi_field)
    else $error("single write did not apply all fields");

  property p_clk_oe;
    clk_en && (outclk_buffer_off || output_buffers_off) |=> !output_clock_oe;
  endproperty
  a_clk_oe: assert property (p_clk_oe)
    else $error("output clock enabled while powered down");

  property p_data_oe;
    clk_en |=> data_oe == !$past(output_buffers_off);
  endproperty
  a_data_oe: assert property (p_data_oe)
    else $error("data enable does not follow buffer power down");

  property p_toggle;
    clk_en && word_load && pattern_sel == 3'h3 && output_word == 14'h2AAA
      |=> output_word == 14'h1555;
  endproperty
  a_toggle: assert property (p_toggle)
    else $error("toggle pattern did not alternate");

  property p_ramp;
    clk_en && word_load && pattern_sel == 3'h4 && ramp_on_ff
      |=> output_word == 14'($past(output_word) + 14'h0001);
  endproperty
  a_ramp: assert property (p_ramp)
    else $error("ramp did not step by one");

  property p_custom;
    clk_en && word_load && pattern_sel == 3'h5
      |=> output_word == {2'h0, $past(user_word_hi), $past(user_word_lo)};
  endproperty
  a_custom: assert property (p_custom)
    else $error("user pattern not driven");

  property p_bitwise;
    clk_en && output_standard_sel && bitwise && !word_load
      |=> ddr_lane == even_bits($past(output_word));
  endproperty
  a_bitwise: assert property (p_bitwise)
    else $error("bit-wise lane order wrong");

  property p_bitwise_fall;
    clk_en && output_standard_sel && bitwise && word_load
      |=> ddr_lane == odd_bits($past(output_word));
  endproperty
  a_bitwise_fall: assert property (p_bitwise_fall)
    else $error("bit-wise fall half wrong");

  property p_bytewise;
    clk_en && output_standard_sel && !bitwise && !word_load
      |=> ddr_lane == $past(output_word[6:0]);
  endproperty
  a_bytewise: assert property (p_bytewise)
    else $error("byte-wise lane order wrong");

  property p_bytewise_fall;
    clk_en && output_standard_sel && !bitwise && word_load
      |=> ddr_lane == $past(output_word[13:7]);
  endproperty
  a_bytewise_fall: assert property (p_bytewise_fall)
    else $error("byte-wise fall half wrong");

  property p_edge;
    clk_en && phase_ff |=> output_clock_pos == !$past(capture_edge_sel);
  endproperty
  a_edge: assert property (p_edge)
    else $error("output clock polarity wrong");

  property p_format;
    clk_en && word_load && pattern_sel == 3'h0 && !code_format_sel
      |=> output_word[13] == !$past(adc_sample[13]);
  endproperty
  a_format: assert property (p_format)
    else $error("two's complement coding wrong");

  property p_launch;
    clk_en && phase_ff != sample_launch_shift |=> $stable(output_word);
  endproperty
  a_launch: assert property (p_launch)
    else $error("data changed in the wrong half cycle");

endmodule : acr_top

/* acr_host_model.sv */
// Purpose: Serial host that writes one frame into the config bank
// Assumes: 80 ns serial clock, pins move just after sys_clk rises
// Notes:   Clock idles low; idle data shows the inverse of the last bit
module acr_host_model (
  input  wire logic sys_clk,
  output logic      ser_clk,
  output logic      ser_enable_n,
  output logic      ser_data
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    ser_clk      = 1'b0;
    ser_enable_n = 1'b1;
    ser_data     = 1'b0;
  end

  task automatic write(input logic [4:0] addr, input logic [10:0] data);
    logic [15:0] frame;
    frame = {addr, data};
    @(posedge sys_clk);
    #1 ser_enable_n = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      repeat (2) @(posedge sys_clk);
      #1 ser_data = frame[i];
      repeat (3) @(posedge sys_clk);
      #1 ser_clk = 1'b1;
      repeat (5) @(posedge sys_clk);
      #1 ser_clk = 1'b0;
    end
    repeat (3) @(posedge sys_clk);
    #1 ser_enable_n = 1'b1;
    ser_data = ~ser_data;
    // Long gap lets the write land before the next frame
    repeat (12) @(posedge sys_clk);
    // Hand back just off the edge so callers never drive on it
    #1;
  endtask : write
endmodule : acr_host_model

/* acr_top_tb.sv */
// Purpose: Self-checking bench for the converter config bank
// Assumes: Expected fields come from shadow copies of each write
// Notes:   Drivers queue notes; a monitor checks them as results show
`include "acr_map.svh"
module acr_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct { int kind; logic [31:0] val; } acr_note_t;
  logic sys_clk = 1'b0, reset_n = 1'b0, clk_en = 1'b1, look = 1'b0;
  logic [13:0] adc_sample, output_word;
  logic ser_clk, ser_enable_n, ser_data, converter_sleep, outclk_buffer_off;
  logic soft_clear, bias_source_sel, output_standard_sel, coarse_boost_sel;
  logic output_buffers_off, outclk_delay_sel, capture_edge_sel;
  logic sample_launch_shift, ddr_order_sel, code_format_sel, data_oe;
  logic output_clock_pos, output_clock_oe;
  logic [2:0] pattern_sel, trim_amplification;
  logic [6:0] user_word_lo, ddr_lane;
  logic [4:0] user_word_hi;
  logic [10:0] r00 = '0, r04 = '0, r09 = '0, r0a = '0, r0b = '0, r0c = '0;
  acr_note_t notes[$], mon_n;
  int err_total = 0, checks_done = 0;
  wire [31:0] cfg_seen = {converter_sleep, outclk_buffer_off,
    bias_source_sel, output_standard_sel, coarse_boost_sel,
    output_buffers_off, outclk_delay_sel, capture_edge_sel,
    sample_launch_shift, ddr_order_sel, pattern_sel, code_format_sel,
    user_word_lo, user_word_hi, trim_amplification, output_clock_oe,
    data_oe, soft_clear};

  acr_host_model i_host (.sys_clk(sys_clk), .ser_clk(ser_clk),
    .ser_enable_n(ser_enable_n), .ser_data(ser_data));
  acr_top i_acr_top (.sys_clk(sys_clk), .reset_n(reset_n),
    .clk_en(clk_en), .ser_clk(ser_clk), .ser_enable_n(ser_enable_n),
    .ser_data(ser_data), .adc_sample(adc_sample),
    .converter_sleep(converter_sleep),
    .outclk_buffer_off(outclk_buffer_off), .soft_clear(soft_clear),
    .bias_source_sel(bias_source_sel),
    .output_standard_sel(output_standard_sel),
    .coarse_boost_sel(coarse_boost_sel),
    .output_buffers_off(output_buffers_off),
    .outclk_delay_sel(outclk_delay_sel),
    .capture_edge_sel(capture_edge_sel),
    .sample_launch_shift(sample_launch_shift),
    .ddr_order_sel(ddr_order_sel), .pattern_sel(pattern_sel),
    .code_format_sel(code_format_sel), .user_word_lo(user_word_lo),
    .user_word_hi(user_word_hi), .trim_amplification(trim_amplification),
    .output_word(output_word), .ddr_lane(ddr_lane),
    .output_clock_pos(output_clock_pos),
    .output_clock_oe(output_clock_oe), .data_oe(data_oe));

  always #4 sys_clk = ~sys_clk;

  function automatic logic [31:0] exp_cfg();
    return {r00[0], r00[2], r00[5], r00[8], r00[9], r00[10], r04[8],
      r04[9], r04[10], r09[10], r0a[7:5], r0a[10], r0b[10:4], r0c[4:0],
      r0c[10:8], ~(r00[2] | r00[10]), ~r00[10], 1'b0};
  endfunction : exp_cfg

  function automatic logic [13:0] exp_word(input int p);
    case (p)
      0: return r0a[10] ? adc_sample : adc_sample ^ 14'h2000;
      2: return 14'h3FFF;
      5: return {2'h0, r0c[4:0], r0b[10:4]};
      default: return 14'h0000;
    endcase
  endfunction : exp_word

  function automatic logic [6:0] pick(input logic [13:0] w, input int odd);
    for (int i = 0; i < 7; i++) pick[i] = w[2 * i + odd];
  endfunction : pick

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : finish_test

  // One note per cycle at most; the monitor clears look as it takes it
  task automatic note(input int kind, input logic [31:0] val);
    notes.push_back('{kind, val});
    look = 1'b1;
  endtask : note

  task automatic wr(input logic [4:0] a, input logic [10:0] d);
    i_host.write(a, d);
    case (a)
      `ACR_REG_PWR:  r00 = d;
      `ACR_REG_TIM:  r04 = d;
      `ACR_REG_DDR:  r09 = d;
      `ACR_REG_FMT:  r0a = d;
      `ACR_REG_ULO:  r0b = d;
      `ACR_REG_TRIM: r0c = d;
      default: ;
    endcase
    if (a == `ACR_REG_PWR && d[`ACR_B_CLEAR])
      {r00, r04, r09, r0a, r0b, r0c} = '0;
    note(0, exp_cfg());
  endtask : wr

  // Stop in the cycle that shows the rising half of a fresh word
  task automatic align();
    int n;
    n = 0;
    do begin
      @(posedge sys_clk);
      #1 n++;
    end while (output_clock_pos !== ~r04[9] && n < 8);
  endtask : align

  task automatic run_seq(input int p, input logic [13:0] last,
                         input logic [13:0] a, input logic [13:0] b);
    int n;
    wr(`ACR_REG_FMT, {3'h0, p[2:0], 5'h00});
    align();
    for (n = 0; n < 20000 && output_word !== last; n++) begin
      repeat (2) @(posedge sys_clk);
      #1;
    end
    repeat (2) @(posedge sys_clk);
    #1 note(1, {18'h0, a});
    repeat (2) @(posedge sys_clk);
    #1 note(1, {18'h0, b});
    // A low enable must hold the word through several edges
    clk_en = 1'b0;
    repeat (5) @(posedge sys_clk);
    #1 note(1, {18'h0, b});
    clk_en = 1'b1;
  endtask : run_seq

  always @(posedge sys_clk) begin
    #2;
    if (look) begin
      look = 1'b0;
      mon_n = notes.pop_front();
      if (mon_n.kind == 0)
        check("config", cfg_seen, mon_n.val);
      else if (mon_n.kind == 1)
        check("word", {18'h0, output_word}, mon_n.val);
      else
        check("lane", {24'h0, output_clock_pos, ddr_lane}, mon_n.val);
    end
  end

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    logic [13:0] w;
    adc_sample = 14'($urandom(42));
    repeat (16) @(posedge sys_clk);
    #1 reset_n = 1'b1;
    repeat (4) @(posedge sys_clk);
    #1 note(0, exp_cfg());
    for (int k = 0; k < 3; k++) begin
      wr(`ACR_REG_PWR, 11'($urandom()) & 11'h725);
      wr(`ACR_REG_TIM, 11'($urandom()) & 11'h700);
      wr(`ACR_REG_DDR, 11'($urandom()) & 11'h400);
      wr(`ACR_REG_FMT, 11'($urandom()) & 11'h4E0);
      wr(`ACR_REG_ULO, 11'($urandom()) & 11'h7F0);
      wr(`ACR_REG_TRIM, 11'($urandom()) & 11'h71F);
    end
    wr(5'h0E, 11'h7FF);
    $display("done: fields");
    wr(`ACR_REG_PWR, 11'h100);
    wr(`ACR_REG_TIM, 11'h000);
    for (int p = 0; p < 8; p++) begin
      if (p != 3 && p != 4) begin
        adc_sample = 14'($urandom());
        wr(`ACR_REG_FMT, {1'($urandom()), 2'h0, p[2:0], 5'h00});
        align();
        note(1, {18'h0, exp_word(p)});
      end
    end
    for (int m = 0; m < 4; m++) begin
      wr(`ACR_REG_FMT, 11'h0A0);
      wr(`ACR_REG_DDR, {m[0], 10'h000});
      wr(`ACR_REG_TIM, {1'b0, m[1], 9'h000});
      w = exp_word(5);
      align();
      note(2, {24'h0, ~r04[9], m[0] ? w[6:0] : pick(w, 0)});
      @(posedge sys_clk);
      #1 note(2, {24'h0, r04[9], m[0] ? w[13:7] : pick(w, 1)});
    end
    $display("done: patterns and lanes");
    run_seq(3, 14'h2AAA, 14'h1555, 14'h2AAA);
    run_seq(4, 14'h3FFF, 14'h0000, 14'h0001);
    $display("done: toggle and ramp");
    wr(`ACR_REG_PWR, 11'h735);
    $display("done: soft clear");
    repeat (4) @(posedge sys_clk);
    finish_test();
  end

  initial begin
    #500000;
    err_total++;
    finish_test();
  end
endmodule : acr_top_tb
